// File: rtrl_regs.svh
// Register offsets, field positions and reset values for the remap/status bank
`ifndef RTRL_REGS_SVH
`define RTRL_REGS_SVH
`define RTRL_IDX_CTRL        8'h04
`define RTRL_IDX_HOLD        8'h06
`define RTRL_IDX_TGT_ADDR    8'h07
`define RTRL_IDX_TGT_ALIAS   8'h08
`define RTRL_IDX_CRC_LO      8'h0A
`define RTRL_IDX_CRC_HI      8'h0B
`define RTRL_IDX_STATUS      8'h0C
`define RTRL_IDX_DESER_ADDR  8'h10
`define RTRL_IDX_IRQ_STAT    8'h11
`define RTRL_IDX_IRQ_MASK    8'h12
`define RTRL_CTRL_CRC_RST    5
`define RTRL_HOLD_BIT        0
`define RTRL_ST_LOST         4
`define RTRL_ST_SELFTEST     3
`define RTRL_ST_CLK          2
`define RTRL_ST_DES_ERR      1
`define RTRL_ST_LINK         0
`define RTRL_RST_BYTE        8'h00
`define RTRL_RST_ADDR7       7'h00
`define RTRL_RST_CNT         16'h0000
`endif

// File: rtrl_pkg.sv
// Types shared by the remap/status bank
package rtrl_pkg;
    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rtrl_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rtrl_apb_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
    } rtrl_xact_t;

    typedef struct packed {
        logic       valid;
        logic       blocked;
        logic [6:0] addr;
    } rtrl_fwd_t;
endpackage

// File: rtrl_sync.sv
// Three-stage input synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module rtrl_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    always_comb
    begin
        out_d = out_q;
        for (int i = 0; i < W; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end
        else
        begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule

// File: rtrl_bank.sv
// Remote target remap and link status register bank with APB slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "rtrl_regs.svh"
module rtrl_bank (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire rtrl_pkg::rtrl_apb_req_t apb_req,
    output rtrl_pkg::rtrl_apb_rsp_t    apb_rsp,
    input  wire logic                  rx_lock,
    input  wire logic [6:0]            chan_deser_addr,
    input  wire logic                  chan_addr_valid,
    input  wire logic                  link_detect_pin,
    input  wire logic                  hdmi_clock_pin,
    input  wire logic                  crc_err_pulse,
    input  wire logic                  selftest_active,
    input  wire logic                  selftest_restart,
    input  wire rtrl_pkg::rtrl_xact_t  xact_in,
    output rtrl_pkg::rtrl_fwd_t        xact_out,
    output logic [6:0]                 remote_deser_address,
    output logic                       irq
);
    import rtrl_pkg::*;

    logic [1:0] pins_s;
    logic       link_s, hdmi_clock_present;
    rtrl_sync #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({hdmi_clock_pin, link_detect_pin}),
        .dout    (pins_s)
    );
    assign link_s             = pins_s[0];
    assign hdmi_clock_present = pins_s[1];

    function automatic logic [6:0] addr7(input logic [7:0] b);
        return b[7:1];
    endfunction

    // Byte address of a word-wide register index
    function automatic logic [7:0] badr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

    logic        wr_en, rd_en, hit;
    logic        crc_rst;
    logic        address_hold_bit_q, address_hold_bit_d;
    logic [6:0]  deser_q, deser_d;
    logic [6:0]  tgt_q, tgt_d;
    logic [6:0]  alias_q, alias_d;
    logic [15:0] cnt_q, cnt_d;
    logic        lost_q, lost_d, st_q, st_d, des_q, des_d, link_q;
    logic [4:0]  ists_q, ists_d, imask_q, imask_d, ev;
    logic [31:0] rdata_q, rdata_d;
    logic        err_q, err_d;
    logic [7:0]  status_b;
    logic        link_fall;
    rtrl_fwd_t   fwd_q, fwd_d;

    assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en   = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign crc_rst = wr_en && (apb_req.paddr == badr(`RTRL_IDX_CTRL))
                     && apb_req.pwdata[`RTRL_CTRL_CRC_RST];
    assign link_fall = link_q && !link_s;

    always_comb
    begin
        status_b = `RTRL_RST_BYTE;
        status_b[`RTRL_ST_LOST]     = lost_q;
        status_b[`RTRL_ST_SELFTEST] = st_q;
        status_b[`RTRL_ST_CLK]      = hdmi_clock_present;
        status_b[`RTRL_ST_DES_ERR]  = des_q;
        status_b[`RTRL_ST_LINK]     = link_s;
    end

    always_comb
    begin
        address_hold_bit_d = address_hold_bit_q;
        deser_d = deser_q;
        tgt_d   = tgt_q;
        alias_d = alias_q;
        imask_d = imask_q;
        if (wr_en)
        begin
            unique case (apb_req.paddr)
                badr(`RTRL_IDX_HOLD):
                    address_hold_bit_d = apb_req.pwdata[`RTRL_HOLD_BIT];
                badr(`RTRL_IDX_DESER_ADDR): deser_d = addr7(apb_req.pwdata[7:0]);
                badr(`RTRL_IDX_TGT_ADDR):   tgt_d   = addr7(apb_req.pwdata[7:0]);
                badr(`RTRL_IDX_TGT_ALIAS):  alias_d = addr7(apb_req.pwdata[7:0]);
                badr(`RTRL_IDX_IRQ_MASK):   imask_d = apb_req.pwdata[4:0];
                default:;
            endcase
        end
        else if (rx_lock && chan_addr_valid && !address_hold_bit_q)
        begin
            deser_d = chan_deser_addr;
        end
    end

    always_comb
    begin
        cnt_d = cnt_q;
        if (crc_rst)
        begin
            cnt_d = `RTRL_RST_CNT;
        end
        else if (crc_err_pulse && cnt_q != 16'hFFFF)
        begin
            cnt_d = cnt_q + 16'h0001;
        end
        lost_d = lost_q;
        if (link_fall)
        begin
            lost_d = 1'b1;
        end
        else if (crc_rst)
        begin
            lost_d = 1'b0;
        end
        st_d = st_q;
        if (link_fall || selftest_restart || crc_rst)
        begin
            st_d = 1'b0;
        end
        else if (crc_err_pulse && selftest_active)
        begin
            st_d = 1'b1;
        end
        des_d = des_q;
        if (link_fall || crc_rst)
        begin
            des_d = 1'b0;
        end
        else if (crc_err_pulse && !selftest_active)
        begin
            des_d = 1'b1;
        end
    end

    always_comb
    begin
        ev = {link_fall, crc_err_pulse && selftest_active, 1'b0,
              crc_err_pulse && !selftest_active, 1'b0};
        ists_d = ists_q;
        // Clear only what the read returned; events after setup survive
        if (rd_en && apb_req.paddr == badr(`RTRL_IDX_IRQ_STAT))
        begin
            ists_d = ists_q & ~rdata_q[4:0];
        end
        ists_d = ists_d | ev;
    end

    always_comb
    begin
        hit     = 1'b1;
        rdata_d = rdata_q;
        err_d   = 1'b0;
        if (apb_req.psel && !apb_req.penable)
        begin
            rdata_d = '0;
            unique case (apb_req.paddr)
                badr(`RTRL_IDX_CTRL):       rdata_d = '0;
                badr(`RTRL_IDX_HOLD):       rdata_d[0] = address_hold_bit_q;
                badr(`RTRL_IDX_DESER_ADDR): rdata_d[7:1] = deser_q;
                badr(`RTRL_IDX_TGT_ADDR):   rdata_d[7:1] = tgt_q;
                badr(`RTRL_IDX_TGT_ALIAS):  rdata_d[7:1] = alias_q;
                badr(`RTRL_IDX_CRC_LO):     rdata_d[7:0] = cnt_q[7:0];
                badr(`RTRL_IDX_CRC_HI):     rdata_d[7:0] = cnt_q[15:8];
                badr(`RTRL_IDX_STATUS):     rdata_d[7:0] = status_b;
                badr(`RTRL_IDX_IRQ_STAT):   rdata_d[4:0] = ists_q;
                badr(`RTRL_IDX_IRQ_MASK):   rdata_d[4:0] = imask_q;
                default:                       hit = 1'b0;
            endcase
            err_d = !hit;
        end
        else if (apb_req.psel)
        begin
            err_d = err_q;
        end
    end

    always_comb
    begin
        fwd_d = '0;
        if (xact_in.valid)
        begin
            fwd_d.valid = 1'b1;
            fwd_d.addr  = xact_in.addr;
            if (alias_q != `RTRL_RST_ADDR7 && xact_in.addr == alias_q)
            begin
                fwd_d.addr    = tgt_q;
                fwd_d.blocked = (tgt_q == `RTRL_RST_ADDR7);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            address_hold_bit_q <= 1'b0;
            deser_q <= `RTRL_RST_ADDR7;
            tgt_q   <= `RTRL_RST_ADDR7;
            alias_q <= `RTRL_RST_ADDR7;
            cnt_q   <= `RTRL_RST_CNT;
            lost_q  <= 1'b0;
            st_q    <= 1'b0;
            des_q   <= 1'b0;
            link_q  <= 1'b0;
            ists_q  <= '0;
            imask_q <= '0;
            rdata_q <= '0;
            err_q   <= 1'b0;
            fwd_q   <= '0;
        end
        else
        begin
            address_hold_bit_q <= address_hold_bit_d;
            deser_q <= deser_d;
            tgt_q   <= tgt_d;
            alias_q <= alias_d;
            cnt_q   <= cnt_d;
            lost_q  <= lost_d;
            st_q    <= st_d;
            des_q   <= des_d;
            link_q  <= link_s;
            ists_q  <= ists_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
            fwd_q   <= fwd_d;
        end
    end

    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && err_q;
    assign apb_rsp.prdata  = rdata_q;
    assign xact_out             = fwd_q;
    assign remote_deser_address = deser_q;
    assign irq                  = |(ists_q & imask_q);

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (address_hold_bit_q && !wr_en) |=> (deser_q == $past(deser_q));
    endproperty
    a_hold: assert property (p_hold) else $error("address changed while held");

    property p_load;
        @(posedge pclk) disable iff (!presetn)
        (!address_hold_bit_q && rx_lock && chan_addr_valid && !wr_en)
            |=> (deser_q == $past(chan_deser_addr));
    endproperty
    a_load: assert property (p_load) else $error("channel address not loaded");

    property p_nolock;
        @(posedge pclk) disable iff (!presetn)
        (!rx_lock && !wr_en) |=> $stable(deser_q);
    endproperty
    a_nolock: assert property (p_nolock) else $error("address loaded without lock");

    property p_remap;
        @(posedge pclk) disable iff (!presetn)
        (xact_in.valid && alias_q != 7'h00 && xact_in.addr == alias_q && !wr_en)
            |=> (xact_out.valid && xact_out.addr == $past(tgt_q));
    endproperty
    a_remap: assert property (p_remap) else $error("alias not remapped");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        (xact_in.valid && alias_q != 7'h00 && xact_in.addr == alias_q && tgt_q == 7'h00)
            |=> xact_out.blocked;
    endproperty
    a_block: assert property (p_block) else $error("zero target not blocked");

    property p_alias0;
        @(posedge pclk) disable iff (!presetn)
        (alias_q == 7'h00) |=> !xact_out.blocked;
    endproperty
    a_alias0: assert property (p_alias0) else $error("zero alias remapped");

    property p_cnt;
        @(posedge pclk) disable iff (!presetn)
        crc_rst |=> (cnt_q == 16'h0000);
    endproperty
    a_cnt: assert property (p_cnt) else $error("counter not cleared");

    sequence s_lost;
        link_fall ##1 lost_q;
    endsequence
    property p_lost;
        @(posedge pclk) disable iff (!presetn)
        (lost_q && !crc_rst) |=> lost_q;
    endproperty
    a_lost: assert property (p_lost) else $error("link lost not sticky");

    property p_lostset;
        @(posedge pclk) disable iff (!presetn)
        link_fall |-> s_lost;
    endproperty
    a_lostset: assert property (p_lostset) else $error("link lost not set");

    property p_st;
        @(posedge pclk) disable iff (!presetn)
        (link_fall || selftest_restart || crc_rst) |=> !st_q;
    endproperty
    a_st: assert property (p_st) else $error("self-test flag not cleared");

    property p_clk;
        @(posedge pclk) disable iff (!presetn)
        (apb_req.psel && !apb_req.penable && apb_req.paddr == badr(`RTRL_IDX_STATUS))
            |=> (rdata_q[2] == $past(hdmi_clock_present) && rdata_q[0] == $past(link_s));
    endproperty
    a_clk: assert property (p_clk) else $error("live status bits wrong");

    property p_des;
        @(posedge pclk) disable iff (!presetn)
        (crc_err_pulse && !selftest_active && !link_fall && !crc_rst) |=> des_q;
    endproperty
    a_des: assert property (p_des) else $error("error flag not set");
endmodule

// File: rtrl_deser_model.sv
// Remote deserializer model for the control channel side of the bank
`timescale 1ns/1ps
module rtrl_deser_model (
    input  wire logic       pclk,
    output logic            rx_lock,
    output logic            addr_valid,
    output logic [6:0]      deser_addr,
    output logic            link_pin,
    output logic            crc_pulse
);
    initial
    begin
        rx_lock = 1'b0;
        addr_valid = 1'b0;
        deser_addr = 7'h7F;
        link_pin = 1'b0;
        crc_pulse = 1'b0;
    end

    // Offer own address in the same cycle as lock, then scramble the released lines
    task automatic offer(input logic [6:0] a, input int n);
        @(posedge pclk);
        rx_lock <= 1'b1;
        addr_valid <= 1'b1;
        deser_addr <= a;
        repeat (n) @(posedge pclk);
        addr_valid <= 1'b0;
        deser_addr <= ~a;
    endtask

    task automatic link_up(input logic up);
        @(posedge pclk);
        link_pin <= up;
        if (!up)
            rx_lock <= 1'b0;
    endtask

    // Gap gives prompt or slow error bursts
    task automatic crc(input int n, input int gap);
        repeat (n)
        begin
            @(posedge pclk);
            crc_pulse <= 1'b1;
            @(posedge pclk);
            crc_pulse <= 1'b0;
            repeat (gap) @(posedge pclk);
        end
    endtask
endmodule

// File: remote_target_remap_link_status_tb.sv
// Testbench for the remote target remap and link status bank
`timescale 1ns/1ps
module remote_target_remap_link_status_tb;
    import rtrl_pkg::*;
    localparam logic [7:0] A_CTRL = 8'h10, A_HOLD = 8'h18, A_TGT = 8'h1C, A_ALIAS = 8'h20;
    localparam logic [7:0] A_CLO = 8'h28, A_CHI = 8'h2C, A_ST = 8'h30, A_DES = 8'h40;
    localparam logic [7:0] A_IST = 8'h44, A_IMSK = 8'h48;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    rtrl_apb_req_t  req = '0;
    rtrl_apb_rsp_t  rsp;
    rtrl_xact_t     xin = '0;
    rtrl_fwd_t      xout;
    logic           lock, vld, link, crc, irq;
    logic [6:0]     caddr, dsa;
    logic           hdmi = 1'b0;
    logic           st_act = 1'b0;
    logic           st_rst = 1'b0;
    int             bad_count = 0;
    int             total_checks = 0;
    int             cycles = 0;
    logic [31:0]    r;
    logic           e;

    always #2.5 pclk = ~pclk;

    rtrl_bank DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .rx_lock(lock), .chan_deser_addr(caddr), .chan_addr_valid(vld),
        .link_detect_pin(link), .hdmi_clock_pin(hdmi), .crc_err_pulse(crc),
        .selftest_active(st_act), .selftest_restart(st_rst), .xact_in(xin),
        .xact_out(xout), .remote_deser_address(dsa), .irq(irq));

    rtrl_deser_model DES (.pclk(pclk), .rx_lock(lock), .addr_valid(vld),
        .deser_addr(caddr), .link_pin(link), .crc_pulse(crc));

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Blocked result carries the zero target address; only valid and blocked are checked
    task automatic fwd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge pclk);
        xin <= '{valid: 1'b1, addr: a};
        @(posedge pclk);
        xin <= '0;
        @(negedge pclk);
        if (exp[7])
            chk(32'(xout[8:7]), 32'h3);
        else
            chk(32'(xout), {23'h000000, 1'b1, exp});
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            test_done;
        end
    end

    initial
    begin
        wt(10);
        presetn <= 1'b1;
        rd(A_TGT, 32'h0);
        rd(A_ALIAS, 32'h0);
        rd(A_CLO, 32'h0);
        rd(A_CHI, 32'h0);
        rd(A_ST, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
        DES.link_up(1'b1);
        hdmi <= 1'b1;
        wt(8);
        rd(A_ST, 32'h5);
        hdmi <= 1'b0;
        wt(8);
        rd(A_ST, 32'h1);
        hdmi <= 1'b1;
        DES.offer(7'h2A, 4);
        rd(A_DES, 32'h54);
        chk(32'(dsa), 32'h2A);
        wr(A_HOLD, 32'h1);
        wr(A_DES, 32'h22);
        DES.offer(7'h15, 4);
        rd(A_DES, 32'h22);
        wr(A_HOLD, 32'h0);
        DES.offer(7'h15, 4);
        rd(A_DES, 32'h2A);
        $display("test address done");
        DES.crc(2, 0);
        st_act <= 1'b1;
        DES.crc(1, 3);
        st_act <= 1'b0;
        rd(A_CLO, 32'h3);
        rd(A_CHI, 32'h0);
        rd(A_ST, 32'h0F);
        chk({31'h0, irq}, 32'h0);
        st_rst <= 1'b1;
        wt(1);
        st_rst <= 1'b0;
        rd(A_ST, 32'h07);
        wr(A_CTRL, 32'h20);
        rd(A_CLO, 32'h0);
        rd(A_ST, 32'h05);
        rd(A_IST, 32'h0A);
        rd(A_IST, 32'h0);
        $display("test crc done");
        wr(A_TGT, 32'hA0);
        wr(A_ALIAS, 32'h60);
        fwd(7'h30, 8'h50);
        fwd(7'h31, 8'h31);
        wr(A_TGT, 32'h0);
        fwd(7'h30, 8'h80);
        wr(A_TGT, 32'hA0);
        wr(A_ALIAS, 32'h0);
        fwd(7'h00, 8'h00);
        $display("test remap done");
        wr(A_IMSK, 32'h10);
        DES.crc(1, 2);
        DES.link_up(1'b0);
        wt(8);
        chk({31'h0, irq}, 32'h1);
        rd(A_ST, 32'h14);
        rd(A_ST, 32'h14);
        rd(A_IST, 32'h12);
        wt(1);
        chk({31'h0, irq}, 32'h0);
        wr(A_CTRL, 32'h20);
        rd(A_ST, 32'h04);
        $display("test link done");
        test_done;
    end
endmodule
